// [hw/tmr8_pkg.sv]
package tmr8_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h24;
  localparam logic [7:0] OFS_CTRL_B = 8'h28;
  localparam logic [7:0] OFS_CMP_A = 8'h2C;
  localparam logic [7:0] OFS_CMP_B = 8'h30;
  localparam logic [7:0] OFS_COUNT = 8'h34;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h38;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h3C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h40;
  localparam logic [7:0] OFS_PORT_DIR = 8'h44;

  // counter limits
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_STEP = 8'h01;

  // field positions and reset values
  localparam int unsigned CTRL_B_MODE_HI = 3;
  localparam int unsigned IRQ_OVF = 0;
  localparam int unsigned IRQ_MATCH_A = 1;
  localparam int unsigned IRQ_MATCH_B = 2;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned DIR_A = 0;
  localparam int unsigned DIR_B = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // output action codes
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOG = 2'h1;
  localparam logic [1:0] ACT_CLR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // waveform mode codes
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PC_FF = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_PC_A = 3'h5;
  localparam logic [2:0] WM_FAST_A = 3'h7;

  typedef struct packed {
    logic [1:0] output_a_action;
    logic [1:0] output_b_action;
    logic [1:0] rsvd;
    logic [1:0] mode_bits_low;
  } tmr8_ctrl_a_t;

  typedef enum logic [4:0] {
    M_NORMAL = 5'h01,
    M_PCPWM = 5'h02,
    M_CTC = 5'h04,
    M_FAST = 5'h08,
    M_RSVD = 5'h10
  } tmr8_mode_t;

  typedef struct packed {
    logic wave_a;
    logic oe_a;
    logic wave_b;
    logic oe_b;
  } tmr8_pins_t;
endpackage

// [hw/tmr8_wave_ctrl.sv]
// Overview of operation
// RULE1 - a nonzero channel A action puts wave output A on its pin, driven only when its direction bit is output.
// RULE2 - in normal and clear-on-match modes action A codes mean off, toggle, clear and set on match.
// RULE3 - in fast PWM action A code two clears on match and sets at TOP, code three does the reverse.
// RULE4 - in PWM modes action A code one toggles on match only with the high mode bit set, else A is disconnected.
// RULE5 - in phase correct PWM action A code two clears on an up match and sets on a down match, code three reverses.
// RULE6 - in PWM modes a match with compare equal to TOP and action high bit set is ignored but TOP action still runs.
// RULE7 - a nonzero channel B action puts wave output B on its pin, driven only when its direction bit is output.
// RULE8 - in normal and clear-on-match modes action B codes mean off, toggle, clear and set on match.
// RULE9 - in fast PWM action B code two clears on match and sets at TOP, code three reverses, code one is reserved.
// RULE10 - in phase correct PWM action B code two clears up and sets down, code three reverses, code one is reserved.
// RULE11 - bits three and two of the first control register always read zero.
// RULE12 - the mode code joins the two low mode bits with the high mode bit of the second control register.
// RULE13 - codes 0,1,3 use TOP 0xFF, 2,5,7 use compare A as TOP, 4 and 6 are reserved.
// RULE14 - overflow sets at MAX in modes 0,2,3, at BOTTOM in modes 1,5 and at TOP in mode 7.
// RULE15 - compare writes act at once in non-PWM modes and are buffered until TOP in PWM modes.
// RULE16 - the high mode bit is bit three of the second control register, read/write, reset zero.
// RULE17 - a match is counter equal to the active compare value, and outputs update in that same cycle; the pins change a clock later.
`timescale 1ns/1ps
module tmr8_wave_ctrl (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // normal port data of the two pins
  input wire logic [1:0] i_port_data,
  // pins, interrupt, counter
  output tmr8_pkg::tmr8_pins_t o_pins,
  output logic o_irq,
  output logic [7:0] o_count
);

  // counting family of a mode code, reserved codes stop the counter
  function automatic tmr8_pkg::tmr8_mode_t mode_of(input logic [2:0] code);
    tmr8_pkg::tmr8_mode_t m;
    case (code)
      tmr8_pkg::WM_NORMAL: m = tmr8_pkg::M_NORMAL;
      tmr8_pkg::WM_CTC: m = tmr8_pkg::M_CTC;
      tmr8_pkg::WM_PC_FF, tmr8_pkg::WM_PC_A: m = tmr8_pkg::M_PCPWM;
      tmr8_pkg::WM_FAST_FF, tmr8_pkg::WM_FAST_A: m = tmr8_pkg::M_FAST;
      default: m = tmr8_pkg::M_RSVD;
    endcase
    return m;
  endfunction

  // next level of one wave output
  function automatic logic wave_next(
    input tmr8_pkg::tmr8_mode_t m,
    input logic [1:0] act,
    input logic tog_ok,
    input logic hit,
    input logic at_top,
    input logic ign,
    input logic up,
    input logic cur
  );
    logic v;
    v = cur;
    case (m)
      tmr8_pkg::M_NORMAL, tmr8_pkg::M_CTC: begin
        case (act)
          tmr8_pkg::ACT_TOG: v = hit ? ~cur : cur;
          tmr8_pkg::ACT_CLR: v = hit ? 1'b0 : cur;
          tmr8_pkg::ACT_SET: v = hit ? 1'b1 : cur;
          default: v = cur;
        endcase
      end
      tmr8_pkg::M_FAST: begin
        if (act == tmr8_pkg::ACT_TOG) begin
          v = (hit && tog_ok) ? ~cur : cur;
        end else if (act[1]) begin
          if (at_top) begin
            v = ~act[0];
          end else if (hit && !ign) begin
            v = act[0];
          end
        end
      end
      tmr8_pkg::M_PCPWM: begin
        if (act == tmr8_pkg::ACT_TOG) begin
          v = (hit && tog_ok) ? ~cur : cur;
        end else if (act[1]) begin
          if (ign) begin
            v = at_top ? ~act[0] : cur;
          end else if (hit) begin
            v = up ? act[0] : ~act[0];
          end
        end
      end
      default: v = cur;
    endcase
    return v;
  endfunction

  tmr8_pkg::tmr8_ctrl_a_t ctrl_a_r;
  logic mode_hi_r;
  logic [7:0] cmp_a_buf_r;
  logic [7:0] cmp_a_r;
  logic [7:0] cmp_b_buf_r;
  logic [7:0] cmp_b_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic down_r;
  logic down_nxt;
  logic block_r;
  logic wave_a_r;
  logic wave_b_r;
  logic wave_a_nxt;
  logic wave_b_nxt;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_en_r;
  logic [2:0] irq_ev;
  logic [1:0] dir_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_data;
  logic rd_ok;
  tmr8_pkg::tmr8_pins_t pins_r;
  tmr8_pkg::tmr8_pins_t pins_nxt;
  logic irq_r;
  logic [2:0] mode_code;
  tmr8_pkg::tmr8_mode_t mode;
  logic pwm;
  logic [7:0] top;
  logic at_top;
  logic up;
  logic hit_a;
  logic hit_b;
  logic ign_a;
  logic ign_b;
  logic conn_a;
  logic conn_b;
  logic acc;
  logic wr;

  assign mode_code = {mode_hi_r, ctrl_a_r.mode_bits_low}; // [RULE12]
  assign mode = mode_of(mode_code); // [RULE13]
  assign pwm = (mode == tmr8_pkg::M_FAST) || (mode == tmr8_pkg::M_PCPWM);
  assign top = (mode_code[2] || mode_code == tmr8_pkg::WM_CTC) ? cmp_a_r : tmr8_pkg::CNT_MAX; // [RULE13]
  assign at_top = (cnt_r == top);
  // a match at bottom counts as up-counting
  assign up = !down_r || (cnt_r == tmr8_pkg::CNT_BOTTOM);
  // a counter write hides the match on the following tick
  assign hit_a = (cnt_r == cmp_a_r) && !block_r; // [RULE17]
  assign hit_b = (cnt_r == cmp_b_r) && !block_r; // [RULE17]
  // compare at top with a set or clear action: only the top action moves the wave
  assign ign_a = pwm && (cmp_a_r == top) && ctrl_a_r.output_a_action[1]; // [RULE6]
  assign ign_b = pwm && (cmp_b_r == top) && ctrl_a_r.output_b_action[1]; // [RULE6]
  // access phase, always the cycle after setup
  assign acc = i_psel && i_penable && pready_r;
  assign wr = acc && i_pwrite;

  // counting sequence
  always_comb begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    case (mode)
      tmr8_pkg::M_NORMAL: cnt_nxt = cnt_r + tmr8_pkg::CNT_STEP;
      tmr8_pkg::M_CTC, tmr8_pkg::M_FAST: begin
        cnt_nxt = at_top ? tmr8_pkg::CNT_BOTTOM : cnt_r + tmr8_pkg::CNT_STEP;
      end
      tmr8_pkg::M_PCPWM: begin
        if (!down_r) begin
          if (at_top) begin
            down_nxt = 1'b1;
            cnt_nxt = cnt_r - tmr8_pkg::CNT_STEP;
          end else begin
            cnt_nxt = cnt_r + tmr8_pkg::CNT_STEP;
          end
        end else if (cnt_r == tmr8_pkg::CNT_BOTTOM) begin
          down_nxt = 1'b0;
          cnt_nxt = cnt_r + tmr8_pkg::CNT_STEP;
        end else begin
          cnt_nxt = cnt_r - tmr8_pkg::CNT_STEP;
        end
      end
      // reserved codes: the counter holds
      default: cnt_nxt = cnt_r;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= tmr8_pkg::RST_BYTE;
      down_r <= 1'b0;
      block_r <= 1'b0;
    end else if (wr && i_paddr == tmr8_pkg::OFS_COUNT) begin
      cnt_r <= i_pwdata[7:0];
      down_r <= down_r;
      block_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      down_r <= down_nxt;
      block_r <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_a_r <= tmr8_pkg::RST_BYTE;
      mode_hi_r <= 1'b0;
      dir_r <= 2'h0;
      irq_en_r <= 3'h0;
    end else begin
      if (wr && i_paddr == tmr8_pkg::OFS_CTRL_A) begin
        ctrl_a_r.output_a_action <= i_pwdata[7:6];
        ctrl_a_r.output_b_action <= i_pwdata[5:4];
        ctrl_a_r.rsvd <= 2'h0; // [RULE11]
        ctrl_a_r.mode_bits_low <= i_pwdata[1:0];
      end
      if (wr && i_paddr == tmr8_pkg::OFS_CTRL_B) begin
        mode_hi_r <= i_pwdata[tmr8_pkg::CTRL_B_MODE_HI]; // [RULE16]
      end
      // direction bits gate the pin drivers only
      if (wr && i_paddr == tmr8_pkg::OFS_PORT_DIR) begin
        dir_r <= i_pwdata[1:0];
      end
      if (wr && i_paddr == tmr8_pkg::OFS_IRQ_EN) begin
        irq_en_r <= i_pwdata[tmr8_pkg::IRQ_W-1:0];
      end
    end
  end

  // compare values, double buffered in pwm modes
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cmp_a_buf_r <= tmr8_pkg::RST_BYTE;
      cmp_a_r <= tmr8_pkg::RST_BYTE;
    end else if (wr && i_paddr == tmr8_pkg::OFS_CMP_A) begin
      cmp_a_buf_r <= i_pwdata[7:0];
      cmp_a_r <= pwm ? cmp_a_r : i_pwdata[7:0]; // [RULE15]
    end else if (!pwm || at_top) begin
      cmp_a_r <= cmp_a_buf_r; // [RULE15]
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cmp_b_buf_r <= tmr8_pkg::RST_BYTE;
      cmp_b_r <= tmr8_pkg::RST_BYTE;
    end else if (wr && i_paddr == tmr8_pkg::OFS_CMP_B) begin
      cmp_b_buf_r <= i_pwdata[7:0];
      cmp_b_r <= pwm ? cmp_b_r : i_pwdata[7:0]; // [RULE15]
    end else if (!pwm || at_top) begin
      cmp_b_r <= cmp_b_buf_r; // [RULE15]
    end
  end

  // waveform outputs
  always_comb begin
    // [RULE2] [RULE3] [RULE4] [RULE5]
    wave_a_nxt = wave_next(mode, ctrl_a_r.output_a_action, mode_hi_r, hit_a, at_top, ign_a, up, wave_a_r);
    // [RULE8] [RULE9] [RULE10]
    wave_b_nxt = wave_next(mode, ctrl_a_r.output_b_action, 1'b0, hit_b, at_top, ign_b, up, wave_b_r);
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end else begin
      wave_a_r <= wave_a_nxt; // [RULE17]
      wave_b_r <= wave_b_nxt; // [RULE17]
    end
  end

  // pin takeover
  always_comb begin
    conn_a = (ctrl_a_r.output_a_action != tmr8_pkg::ACT_OFF);
    if (pwm && ctrl_a_r.output_a_action == tmr8_pkg::ACT_TOG && !mode_hi_r) begin
      conn_a = 1'b0; // [RULE4]
    end
    conn_b = (ctrl_a_r.output_b_action != tmr8_pkg::ACT_OFF); // [RULE7]
    pins_nxt.wave_a = conn_a ? wave_a_nxt : i_port_data[0]; // [RULE1]
    pins_nxt.oe_a = dir_r[tmr8_pkg::DIR_A]; // [RULE1]
    pins_nxt.wave_b = conn_b ? wave_b_nxt : i_port_data[1]; // [RULE7]
    pins_nxt.oe_b = dir_r[tmr8_pkg::DIR_B]; // [RULE7]
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pins_r <= '0;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  // interrupt status, set wins over clear
  always_comb begin
    irq_ev = 3'h0;
    // match flags follow the raw match, even where the wave ignores it
    irq_ev[tmr8_pkg::IRQ_MATCH_A] = hit_a;
    irq_ev[tmr8_pkg::IRQ_MATCH_B] = hit_b;
    case (mode_code)
      tmr8_pkg::WM_NORMAL, tmr8_pkg::WM_CTC, tmr8_pkg::WM_FAST_FF: begin
        irq_ev[tmr8_pkg::IRQ_OVF] = (cnt_r == tmr8_pkg::CNT_MAX); // [RULE14]
      end
      tmr8_pkg::WM_PC_FF, tmr8_pkg::WM_PC_A: begin
        irq_ev[tmr8_pkg::IRQ_OVF] = down_r && (cnt_r == tmr8_pkg::CNT_BOTTOM); // [RULE14]
      end
      tmr8_pkg::WM_FAST_A: irq_ev[tmr8_pkg::IRQ_OVF] = at_top; // [RULE14]
      default: irq_ev[tmr8_pkg::IRQ_OVF] = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      if (wr && i_paddr == tmr8_pkg::OFS_IRQ_CLR) begin
        irq_stat_r <= (irq_stat_r & ~i_pwdata[tmr8_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_r <= irq_stat_r | irq_ev;
      end
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  // read decode
  always_comb begin
    rd_data = tmr8_pkg::RST_WORD;
    rd_ok = 1'b1;
    case (i_paddr)
      tmr8_pkg::OFS_CTRL_A: rd_data[7:0] = {ctrl_a_r[7:4], 2'h0, ctrl_a_r[1:0]}; // [RULE11]
      tmr8_pkg::OFS_CTRL_B: rd_data[tmr8_pkg::CTRL_B_MODE_HI] = mode_hi_r;
      tmr8_pkg::OFS_CMP_A: rd_data[7:0] = cmp_a_buf_r;
      tmr8_pkg::OFS_CMP_B: rd_data[7:0] = cmp_b_buf_r;
      tmr8_pkg::OFS_COUNT: rd_data[7:0] = cnt_r;
      tmr8_pkg::OFS_IRQ_STAT: rd_data[tmr8_pkg::IRQ_W-1:0] = irq_stat_r;
      tmr8_pkg::OFS_IRQ_CLR: rd_data = tmr8_pkg::RST_WORD;
      tmr8_pkg::OFS_IRQ_EN: rd_data[tmr8_pkg::IRQ_W-1:0] = irq_en_r;
      tmr8_pkg::OFS_PORT_DIR: rd_data[1:0] = dir_r;
      default: rd_ok = 1'b0;
    endcase
  end

  // apb answer, ready one cycle after setup
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= tmr8_pkg::RST_WORD;
    // answer prepared in setup so the access phase needs no wait state
    end else if (i_psel && !i_penable) begin
      pready_r <= 1'b1;
      pslverr_r <= !rd_ok;
      prdata_r <= i_pwrite ? tmr8_pkg::RST_WORD : rd_data;
    end else if (acc) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= tmr8_pkg::RST_WORD;
    end
  end

  // every output straight from its register
  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_pins = pins_r;
  assign o_irq = irq_r;
  assign o_count = cnt_r;

endmodule

// [test/tmr8_wave_checker.sv]
`timescale 1ns/1ps
module tmr8_wave_checker (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // pins, interrupt, counter
  input wire logic [1:0] i_port_data,
  input wire tmr8_pkg::tmr8_pins_t o_pins,
  input wire logic o_irq,
  input wire logic [7:0] o_count
);
  logic wr, cnt_wr, hi_r, dir_r;
  logic [7:0] ctl_r, cpa_r, cpb_r;
  logic [2:0] md;
  assign wr = i_psel && i_penable && o_pready && i_pwrite;
  assign cnt_wr = wr && (i_paddr == tmr8_pkg::OFS_COUNT);
  assign md = {hi_r, ctl_r[1:0]};
  // shadow of the registers the properties depend on
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctl_r <= 8'h00;
      cpa_r <= 8'h00;
      cpb_r <= 8'h00;
      hi_r <= 1'b0;
      dir_r <= 1'b0;
    end else if (wr) begin
      if (i_paddr == tmr8_pkg::OFS_CTRL_A) ctl_r <= i_pwdata[7:0];
      if (i_paddr == tmr8_pkg::OFS_CMP_A) cpa_r <= i_pwdata[7:0];
      if (i_paddr == tmr8_pkg::OFS_CMP_B) cpb_r <= i_pwdata[7:0];
      if (i_paddr == tmr8_pkg::OFS_CTRL_B) hi_r <= i_pwdata[3];
      if (i_paddr == tmr8_pkg::OFS_PORT_DIR) dir_r <= i_pwdata[0];
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_hit_a;
    md == 3'h0 && ctl_r[7] && o_count == cpa_r && !wr && !$past(cnt_wr);
  endsequence
  sequence s_hit_b;
    md == 3'h0 && ctl_r[5:4] == 2'h1 && o_count == cpb_r && !wr && !$past(cnt_wr);
  endsequence
  a_ready_after_setup: assert property (s_setup |=> o_pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready held past one cycle");
  a_rsvd_read_zero: assert property (
    o_pready && !i_pwrite && i_paddr == tmr8_pkg::OFS_CTRL_A |-> o_prdata[3:2] == 2'h0)
    else $error("reserved control bits read nonzero");
  a_oe_follows_dir: assert property (dir_r == $past(dir_r) |-> o_pins.oe_a == dir_r)
    else $error("pin a driver not following direction");
  a_count_step: assert property (
    !$past(i_rst) && $past(md) == 3'h0 && !$past(cnt_wr) |-> o_count == $past(o_count) + 8'h01)
    else $error("normal mode count did not step");
  a_match_a_level: assert property (s_hit_a |=> o_pins.wave_a == $past(ctl_r[6]))
    else $error("wave a wrong after match");
  a_top_action_a: assert property (
    md == 3'h3 && ctl_r[7] && o_count == 8'hFF && !wr |=> o_pins.wave_a == !$past(ctl_r[6]))
    else $error("wave a wrong after top");
  a_toggle_b: assert property (s_hit_b |=> o_pins.wave_b != $past(o_pins.wave_b))
    else $error("wave b did not toggle");
endmodule
bind tmr8_wave_ctrl tmr8_wave_checker tmr8_wave_checker_i (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_port_data(i_port_data), .o_pins(o_pins), .o_irq(o_irq), .o_count(o_count));

// [test/tmr8_pin_model.sv]
`timescale 1ns/1ps
module tmr8_pin_model (
  // pins from the block
  input wire tmr8_pkg::tmr8_pins_t i_pins,
  // pad levels, pulled up while undriven
  output logic [1:0] o_pad
);
  assign o_pad[0] = i_pins.oe_a ? i_pins.wave_a : 1'b1;
  assign o_pad[1] = i_pins.oe_b ? i_pins.wave_b : 1'b1;
endmodule

// [test/tb_tmr8_wave_ctrl.sv]
`timescale 1ns/1ps
module tb_tmr8_wave_ctrl;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} tmr8_row_t;
  logic i_mclk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq, er;
  logic [7:0] i_paddr, o_count;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [1:0] i_port_data, pad, ex;
  tmr8_pkg::tmr8_pins_t o_pins;
  int miscompares, samples_checked;
  tmr8_row_t rows [5] = '{
    '{tmr8_pkg::OFS_CTRL_A, 32'hFF, 32'hF3},
    '{tmr8_pkg::OFS_CTRL_B, 32'hFF, 32'h08},
    '{tmr8_pkg::OFS_CMP_A, 32'h5A, 32'h5A},
    '{tmr8_pkg::OFS_PORT_DIR, 32'h3, 32'h3},
    '{tmr8_pkg::OFS_IRQ_CLR, 32'h7, 32'h0}};
  tmr8_wave_ctrl tmr8_wave_ctrl_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_port_data(i_port_data), .o_pins(o_pins), .o_irq(o_irq), .o_count(o_count));
  tmr8_pin_model tmr8_pin_model_i (.i_pins(o_pins), .o_pad(pad));
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    $display("unexpected wait: expected done seen timeout");
    test_done();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (o_pready !== 1'b1) hang();
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // waits for the edge seen with count c, then lets it settle
  task automatic wait_cnt(input logic [7:0] c);
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_count !== c && n < 600);
    if (o_count !== c) hang();
    #1;
  endtask
  task automatic do_reset();
    i_rst <= 1'b1;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
  endtask
  initial begin
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_port_data = 2'h1;
    miscompares = 0;
    samples_checked = 0;
    do_reset();
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].w);
      xfer(1'b0, rows[i].a, 32'h0);
      chk("register", rows[i].e, rd);
    end
    $display("register table done");
    do_reset();
    xfer(1'b0, tmr8_pkg::OFS_CTRL_B, 32'h0);
    chk("ctrl b reset", 32'h0, rd);
    xfer(1'b0, 8'h00, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    $display("reset and unmapped done");
    xfer(1'b1, tmr8_pkg::OFS_PORT_DIR, 32'h3);
    xfer(1'b1, tmr8_pkg::OFS_CMP_A, 32'h10);
    xfer(1'b1, tmr8_pkg::OFS_CMP_B, 32'h20);
    ex = 2'h0;
    for (int c = 3; c >= 0; c--) begin
      xfer(1'b1, tmr8_pkg::OFS_COUNT, 32'h0);
      xfer(1'b1, tmr8_pkg::OFS_CTRL_A, 32'(c * 8'h50));
      wait_cnt(8'h22);
      ex = (c == 1) ? ~ex : ((c == 0) ? i_port_data : {2{c[0]}});
      chk("normal pins", {30'h0, ex}, {30'h0, pad});
    end
    $display("normal actions done");
    xfer(1'b1, tmr8_pkg::OFS_CMP_A, 32'h40);
    xfer(1'b1, tmr8_pkg::OFS_CMP_B, 32'h40);
    xfer(1'b1, tmr8_pkg::OFS_CTRL_A, 32'hB3);
    wait_cnt(8'hFF);
    wait_cnt(8'h10);
    chk("fast pins top", 32'h1, {30'h0, pad});
    xfer(1'b1, tmr8_pkg::OFS_CMP_A, 32'h60);
    wait_cnt(8'h50);
    chk("fast pins match", 32'h2, {30'h0, pad});
    wait_cnt(8'hFF);
    wait_cnt(8'h50);
    chk("fast pins reload", 32'h3, {30'h0, pad});
    xfer(1'b1, tmr8_pkg::OFS_CMP_A, 32'hFF);
    wait_cnt(8'hFF);
    wait_cnt(8'hFF);
    chk("fast compare at top", 32'h1, {31'h0, pad[0]});
    $display("fast pwm done");
    xfer(1'b1, tmr8_pkg::OFS_CMP_A, 32'h80);
    xfer(1'b1, tmr8_pkg::OFS_CMP_B, 32'h80);
    xfer(1'b1, tmr8_pkg::OFS_CTRL_A, 32'hB1);
    wait_cnt(8'hFF);
    chk("phase compare at top", 32'h3, {30'h0, pad});
    wait_cnt(8'h70);
    chk("phase pins down", 32'h1, {30'h0, pad});
    wait_cnt(8'h00);
    wait_cnt(8'h90);
    chk("phase pins up", 32'h2, {30'h0, pad});
    xfer(1'b1, tmr8_pkg::OFS_CTRL_A, 32'h71);
    i_port_data <= 2'h3;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("toggle without high bit", 32'h1, {31'h0, pad[0]});
    $display("phase correct done");
    xfer(1'b1, tmr8_pkg::OFS_IRQ_EN, 32'h1);
    xfer(1'b1, tmr8_pkg::OFS_IRQ_CLR, 32'h7);
    wait_cnt(8'h80);
    chk("no overflow at top", 32'h0, {31'h0, o_irq});
    wait_cnt(8'h00);
    wait_cnt(8'h02);
    chk("overflow at bottom", 32'h1, {31'h0, o_irq});
    xfer(1'b1, tmr8_pkg::OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge i_mclk);
    #1;
    chk("masked irq", 32'h0, {31'h0, o_irq});
    xfer(1'b0, tmr8_pkg::OFS_IRQ_STAT, 32'h0);
    chk("overflow status", 32'h1, {31'h0, rd[0]});
    xfer(1'b1, tmr8_pkg::OFS_IRQ_CLR, 32'h1);
    xfer(1'b0, tmr8_pkg::OFS_IRQ_STAT, 32'h0);
    chk("cleared status", 32'h0, {31'h0, rd[0]});
    $display("interrupt done");
    xfer(1'b1, tmr8_pkg::OFS_CTRL_A, 32'h2);
    xfer(1'b1, tmr8_pkg::OFS_CMP_A, 32'h30);
    xfer(1'b1, tmr8_pkg::OFS_COUNT, 32'h0);
    wait_cnt(8'h30);
    chk("clear on match wrap", 32'h0, {24'h0, o_count});
    xfer(1'b1, tmr8_pkg::OFS_CTRL_B, 32'h8);
    xfer(1'b1, tmr8_pkg::OFS_CTRL_A, 32'h0);
    xfer(1'b1, tmr8_pkg::OFS_COUNT, 32'h5A);
    repeat (3) @(posedge i_mclk);
    #1;
    chk("reserved mode hold", 32'h5A, {24'h0, o_count});
    xfer(1'b1, tmr8_pkg::OFS_PORT_DIR, 32'h0);
    i_port_data <= 2'h0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("released pads", 32'h3, {30'h0, pad});
    $display("mode table done");
    test_done();
  end
endmodule
